//--- shared/srt_defs.svh
`ifndef SRT_DEFS_SVH
`define SRT_DEFS_SVH
`define SRT_OFF_CTRL   8'h00
`define SRT_OFF_RUN    8'h04
`define SRT_OFF_RCCON  8'h08
`define SRT_OFF_CNT    8'h0c
`define SRT_OFF_RC0    8'h10
`define SRT_OFF_RC1    8'h14
`define SRT_OFF_OUTPUT_SOURCE_SELECT   8'h18
`define SRT_RST_ZERO   32'h0000_0000
`define SRT_MSK_CTRL   32'h11ff_91ff
`define SRT_MSK_RCCON  32'h0077_0077
`define SRT_MSK_OUTPUT_SOURCE_SELECT   32'h7777_7777
`define SRT_MSK_NBRUN  32'h0000_00ff
`define SRT_MAX32      32'hffff_ffff
`define SRT_MAX16      32'h0000_ffff
`define SRT_F_LO_CSRC  1:0
`define SRT_F_LO_CDIR  3:2
`define SRT_F_LO_CCLR  5:4
`define SRT_F_HI_CSRC  17:16
`define SRT_F_HI_CDIR  19:18
`define SRT_F_HI_CCLR  21:20
`define SRT_B_LO_DIR   12
`define SRT_B_HI_DIR   28
`define SRT_B_SPLIT    15
`define SRT_B_LO_RUN   8
`define SRT_B_LO_SET   9
`define SRT_B_LO_CLR   10
`define SRT_B_HI_RUN   12
`define SRT_B_HI_SET   13
`define SRT_B_HI_CLR   14
`define SRT_F_LO_M0    2:0
`define SRT_F_LO_M1    6:4
`define SRT_F_HI_M0    18:16
`define SRT_F_HI_M1    22:20
`define SRT_SRC_EXT    2'h1
`define SRT_SRC_QUAD   2'h2
`define SRT_SRC_CLK    2'h0
`define SRT_DIR_UP     2'h0
`define SRT_DIR_DOWN   2'h1
`define SRT_DIR_PINUP  2'h2
`define SRT_CLR_EXT    2'h0
`define SRT_CLR_CAP0   2'h1
`define SRT_CLR_CAP1   2'h2
`define SRT_MD_CAP     3'h3
`define SRT_MD_RLWRAP  3'h4
`define SRT_MD_RLEXT   3'h5
`define SRT_MD_RLOU    3'h6
`define SRT_MD_RLDIR   3'h7
`define SRT_OS_LOWRAP  3'h4
`define SRT_OS_HIWRAP  3'h5
`endif

//--- shared/srt_pkg.sv
package srt_pkg;
    typedef struct packed {
        logic cnt;
        logic ud;
        logic clr;
        logic ev0;
        logic ev1;
        logic start;
        logic stop;
    } srt_hpin_s;
    typedef struct packed {
        srt_hpin_s hi;
        srt_hpin_s lo;
    } srt_pin_s;
    typedef struct packed {
        logic [31:0] cnt;
        logic        cap0;
        logic        cap1;
        logic        wrap;
    } srt_hres_s;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] run;
        logic [31:0] rccon;
        logic [31:0] cnt;
        logic [31:0] rc0;
        logic [31:0] rc1;
        logic [31:0] output_source_select;
        srt_pin_s    sync1;
        srt_pin_s    sync2;
        srt_pin_s    prev;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  outev;
    } srt_state_s;
endpackage

//--- hw/srt_timer.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.svh"

// Contract
// - Clear code 10 clears the half on its capture 1 event; 11 reserved.
// - Clear code 00 clears on external clear event; 01 on capture 0 event.
// - Clear on capture copies the count first, then clears the counter.
// - Direction code 00 counts up, 01 counts down, set by software.
// - Direction code 10 counts up while the up/down pin is 1.
// - Direction code 11 counts down while the up/down pin is 1.
// - Quadrature mode takes direction from pin phase; direction field ignored.
// - Up/down edge setting never affects direction control.
// - Count source 00 module clock, 01 count pin, 10 quadrature, 11 reserved.
// - Run bits 0 to 7 for neighbour timers; one write starts several.
// - Bit 8 is lower run flag, set by hardware; direct writes ignored.
// - Bit 9 sets, bit 10 clears lower run flag; both read zero.
// - Set and clear together leave the flag; software beats hardware.
// - Upper half run flag, set and clear sit at bits 12, 13, 14.
// - Mode 000 disabled, 001 and 010 reserved, 011 captures on event.
// - Mode 100 reloads on wrap, mode 101 reloads on external event.
// - Mode 110 reloads register 0 on overflow, register 1 on underflow.
// - Mode 111 reloads on event, register 0 counting up, 1 down.
// - Direction status reads 0 up, 1 down, at bits 12 and 28.
// - Coinciding capture and reload: capture the old count, then reload.
// - Coinciding reloads from both registers: only register 1 reloads.
// - Split bit 0 gives one 32-bit timer, 1 gives two 16-bit timers.
// - Count register readable and writable; halves at 15:0 and 31:16.
// - Reload/capture registers split likewise and are overwritten on capture.
// - Eight 3-bit output selects every fourth bit; 000 trigger 0, 100 lo wrap.
module srt_timer
    import srt_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output var  logic [31:0] prdata_out,
    output var  logic        pready_out,
    output var  logic        pslverr_out,
    input  wire srt_pin_s    pins_in,
    input  wire logic [3:0]  nb_trigger_in,
    output var  logic [7:0]  nb_timer_run_out,
    output var  logic [7:0]  out_event_out
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic count_up(
        input logic [1:0] cdir,
        input logic [1:0] csrc,
        input srt_hpin_s  cur,
        input srt_hpin_s  old
    );
        logic up;
        begin
            up = 1'b1;
            if (csrc == `SRT_SRC_QUAD)
            begin
                // Count pin edge: up if pins differ; up/down edge: up if equal
                if (cur.cnt != old.cnt)
                    up = cur.cnt ^ cur.ud;
                else
                    up = ~(cur.cnt ^ cur.ud);
            end
            else if (cdir == `SRT_DIR_UP)
                up = 1'b1;
            else if (cdir == `SRT_DIR_DOWN)
                up = 1'b0;
            else if (cdir == `SRT_DIR_PINUP)
                up = cur.ud;
            else
                up = ~cur.ud;
            // Level only, so edge selection cannot reach the direction
            return up;
        end
    endfunction

    function automatic logic count_tick(
        input logic [1:0] csrc,
        input logic       run,
        input srt_hpin_s  cur,
        input srt_hpin_s  old
    );
        logic t;
        begin
            t = 1'b0;
            if (csrc == `SRT_SRC_CLK)
                t = 1'b1;
            else if (csrc == `SRT_SRC_EXT)
                t = cur.cnt & ~old.cnt;
            else if (csrc == `SRT_SRC_QUAD)
                t = (cur.cnt ^ old.cnt) | (cur.ud ^ old.ud);
            // Reserved source 11 never ticks
            return t & run;
        end
    endfunction

    function automatic srt_hres_s half_step(
        input logic [31:0] cnt,
        input logic [31:0] rc0,
        input logic [31:0] rc1,
        input logic [31:0] max,
        input logic        tick,
        input logic        up,
        input logic        dn_st,
        input logic        e0,
        input logic        e1,
        input logic        ce,
        input logic [1:0]  clc,
        input logic [2:0]  m0,
        input logic [2:0]  m1
    );
        srt_hres_s r;
        logic      ovf;
        logic      unf;
        logic      rl0;
        logic      rl1;
        logic      clr;
        begin
            ovf = tick & up & (cnt == max);
            unf = tick & ~up & (cnt == `SRT_RST_ZERO);
            r.wrap = ovf | unf;
            // Captures always see the count before this cycle's update
            r.cap0 = (m0 == `SRT_MD_CAP) & e0;
            r.cap1 = (m1 == `SRT_MD_CAP) & e1;
            r.cnt = cnt;
            if (tick)
                r.cnt = (up ? cnt + 32'h1 : cnt - 32'h1) & max;
            clr = ((clc == `SRT_CLR_EXT) & ce)
                | ((clc == `SRT_CLR_CAP0) & e0)
                | ((clc == `SRT_CLR_CAP1) & e1);
            // Reloads come after the clear, so a reload wins
            if (clr)
                r.cnt = `SRT_RST_ZERO;
            rl0 = ((m0 == `SRT_MD_RLWRAP) & r.wrap)
                | ((m0 == `SRT_MD_RLEXT) & e0)
                | ((m0 == `SRT_MD_RLOU) & ovf)
                | ((m0 == `SRT_MD_RLDIR) & e0 & ~dn_st);
            rl1 = ((m1 == `SRT_MD_RLWRAP) & r.wrap)
                | ((m1 == `SRT_MD_RLEXT) & e1)
                | ((m1 == `SRT_MD_RLOU) & unf)
                | ((m1 == `SRT_MD_RLDIR) & e1 & dn_st);
            if (rl0)
                r.cnt = rc0 & max;
            // Register 1 applied last so it alone wins a double reload
            if (rl1)
                r.cnt = rc1 & max;
            return r;
        end
    endfunction

    function automatic logic [31:0] apply_run(
        input logic [31:0] run,
        input logic        hw_set,
        input logic        hw_clr,
        input logic        wr,
        input logic [31:0] wd,
        input int          fb
    );
        logic [31:0] r;
        begin
            r = run;
            if (hw_set)
                r[fb] = 1'b1;
            if (hw_clr)
                r[fb] = 1'b0;
            // Software set/clear overrides any hardware change this cycle
            if (wr && wd[fb + 1] && !wd[fb + 2])
                r[fb] = 1'b1;
            else if (wr && wd[fb + 2] && !wd[fb + 1])
                r[fb] = 1'b0;
            else if (wr && wd[fb + 1] && wd[fb + 2])
                r[fb] = run[fb];
            return r;
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    srt_state_s s_ff;
    srt_state_s nxt_s;
    srt_pin_s   rise;
    srt_hres_s  rl;
    srt_hres_s  rh;
    logic       split;
    logic       lo_up;
    logic       hi_up;
    logic       lo_tick;
    logic       hi_tick;
    logic       access;
    logic       wr;
    logic       mapped;
    logic [31:0] rdv;
    logic [2:0]  sel;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_s = s_ff;
        rdv = `SRT_RST_ZERO;
        mapped = 1'b1;
        sel = 3'h0;
        // Pins are asynchronous: only the second stage and the edge history feed logic
        nxt_s.sync1 = pins_in;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.prev = s_ff.sync2;
        // History resets low like idle pins, so no false edge after reset
        rise = srt_pin_s'(s_ff.sync2 & ~s_ff.prev);
        split = s_ff.ctrl[`SRT_B_SPLIT];

        lo_up = count_up(s_ff.ctrl[`SRT_F_LO_CDIR], s_ff.ctrl[`SRT_F_LO_CSRC],
                         s_ff.sync2.lo, s_ff.prev.lo);
        hi_up = count_up(s_ff.ctrl[`SRT_F_HI_CDIR], s_ff.ctrl[`SRT_F_HI_CSRC],
                         s_ff.sync2.hi, s_ff.prev.hi);
        lo_tick = count_tick(s_ff.ctrl[`SRT_F_LO_CSRC], s_ff.run[`SRT_B_LO_RUN],
                             s_ff.sync2.lo, s_ff.prev.lo);
        hi_tick = count_tick(s_ff.ctrl[`SRT_F_HI_CSRC], s_ff.run[`SRT_B_HI_RUN],
                             s_ff.sync2.hi, s_ff.prev.hi) & split;

        // Unsplit: lower controls drive all 32 bits
        rl = half_step(split ? {16'h0, s_ff.cnt[15:0]} : s_ff.cnt,
                       split ? {16'h0, s_ff.rc0[15:0]} : s_ff.rc0,
                       split ? {16'h0, s_ff.rc1[15:0]} : s_ff.rc1,
                       split ? `SRT_MAX16 : `SRT_MAX32,
                       lo_tick, lo_up, s_ff.ctrl[`SRT_B_LO_DIR],
                       rise.lo.ev0, rise.lo.ev1, rise.lo.clr,
                       s_ff.ctrl[`SRT_F_LO_CCLR],
                       s_ff.rccon[`SRT_F_LO_M0], s_ff.rccon[`SRT_F_LO_M1]);
        rh = half_step({16'h0, s_ff.cnt[31:16]},
                       {16'h0, s_ff.rc0[31:16]},
                       {16'h0, s_ff.rc1[31:16]},
                       `SRT_MAX16,
                       hi_tick, hi_up, s_ff.ctrl[`SRT_B_HI_DIR],
                       rise.hi.ev0 & split, rise.hi.ev1 & split,
                       rise.hi.clr & split,
                       s_ff.ctrl[`SRT_F_HI_CCLR],
                       s_ff.rccon[`SRT_F_HI_M0], s_ff.rccon[`SRT_F_HI_M1]);

        // In 32-bit mode the upper half result is dropped
        nxt_s.cnt = split ? {rh.cnt[15:0], rl.cnt[15:0]} : rl.cnt;
        if (rl.cap0)
        begin
            if (split)
                nxt_s.rc0[15:0] = s_ff.cnt[15:0];
            else
                nxt_s.rc0 = s_ff.cnt;
        end
        if (rl.cap1)
        begin
            if (split)
                nxt_s.rc1[15:0] = s_ff.cnt[15:0];
            else
                nxt_s.rc1 = s_ff.cnt;
        end
        if (rh.cap0)
            nxt_s.rc0[31:16] = s_ff.cnt[31:16];
        if (rh.cap1)
            nxt_s.rc1[31:16] = s_ff.cnt[31:16];

        // Quadrature keeps the last counted direction between edges
        if ((s_ff.ctrl[`SRT_F_LO_CSRC] != `SRT_SRC_QUAD) || lo_tick)
            nxt_s.ctrl[`SRT_B_LO_DIR] = ~lo_up;
        if (split && ((s_ff.ctrl[`SRT_F_HI_CSRC] != `SRT_SRC_QUAD) || hi_tick))
            nxt_s.ctrl[`SRT_B_HI_DIR] = ~hi_up;

        // Output source selection per output
        for (int i = 0; i < 8; i++)
        begin
            sel = s_ff.output_source_select[4 * i +: 3];
            if (sel[2] == 1'b0)
                nxt_s.outev[i] = nb_trigger_in[sel[1:0]];
            else if (sel == `SRT_OS_LOWRAP)
                nxt_s.outev[i] = rl.wrap;
            else if (sel == `SRT_OS_HIWRAP)
                nxt_s.outev[i] = rh.wrap;
            else
                nxt_s.outev[i] = 1'b0;
        end

        // ****************************************
        // APB slave, one wait state
        // ****************************************
        access = psel_in & penable_in;
        wr = access & s_ff.pready & pwrite_in;
        if (paddr_in == `SRT_OFF_CTRL)
            rdv = s_ff.ctrl;
        else if (paddr_in == `SRT_OFF_RUN)
            rdv = s_ff.run & 32'h0000_11ff;
        else if (paddr_in == `SRT_OFF_RCCON)
            rdv = s_ff.rccon;
        else if (paddr_in == `SRT_OFF_CNT)
            rdv = s_ff.cnt;
        else if (paddr_in == `SRT_OFF_RC0)
            rdv = s_ff.rc0;
        else if (paddr_in == `SRT_OFF_RC1)
            rdv = s_ff.rc1;
        else if (paddr_in == `SRT_OFF_OUTPUT_SOURCE_SELECT)
            rdv = s_ff.output_source_select;
        else
            mapped = 1'b0;

        // Fixed single wait state; the counter never stalls the bus
        nxt_s.pready = access & ~s_ff.pready;
        if (access & ~s_ff.pready)
        begin
            nxt_s.prdata = (pwrite_in | ~mapped) ? `SRT_RST_ZERO : rdv;
            nxt_s.pslverr = ~mapped;
        end
        else
        begin
            nxt_s.prdata = `SRT_RST_ZERO;
            nxt_s.pslverr = 1'b0;
        end

        // Stop beats start when both pins rise in one cycle
        nxt_s.run = apply_run(s_ff.run, rise.lo.start, rise.lo.stop,
                              wr && paddr_in == `SRT_OFF_RUN, pwdata_in,
                              `SRT_B_LO_RUN);
        nxt_s.run = apply_run(nxt_s.run, rise.hi.start & split,
                              rise.hi.stop & split,
                              wr && paddr_in == `SRT_OFF_RUN, pwdata_in,
                              `SRT_B_HI_RUN);

        // Software writes last, so they beat same-cycle hardware updates
        if (wr)
        begin
            if (paddr_in == `SRT_OFF_CTRL)
                nxt_s.ctrl = pwdata_in & `SRT_MSK_CTRL;
            else if (paddr_in == `SRT_OFF_RUN)
                nxt_s.run[7:0] = pwdata_in[7:0];
            else if (paddr_in == `SRT_OFF_RCCON)
                nxt_s.rccon = pwdata_in & `SRT_MSK_RCCON;
            else if (paddr_in == `SRT_OFF_CNT)
                nxt_s.cnt = pwdata_in;
            else if (paddr_in == `SRT_OFF_RC0)
                nxt_s.rc0 = pwdata_in;
            else if (paddr_in == `SRT_OFF_RC1)
                nxt_s.rc1 = pwdata_in;
            else if (paddr_in == `SRT_OFF_OUTPUT_SOURCE_SELECT)
                nxt_s.output_source_select = pwdata_in & `SRT_MSK_OUTPUT_SOURCE_SELECT;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            // Also clears synchronisers and edge history
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign prdata_out = s_ff.prdata;
    assign pready_out = s_ff.pready;
    assign pslverr_out = s_ff.pslverr;
    assign nb_timer_run_out = s_ff.run[7:0];
    assign out_event_out = s_ff.outev;

endmodule
`default_nettype wire

//--- testbench/srt_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// External pin and trigger model
// ****************
module srt_pins_model
    import srt_pkg::*;
(
    input  wire logic       clk_in,
    output var  srt_pin_s   pins_out,
    output var  logic [3:0] trig_out
);
    initial
    begin
        pins_out = '0;
        trig_out = '0;
    end
    // Held 4 cycles: the 2-FF sync plus edge detect must see it
    task automatic pulse(input logic [13:0] m);
        @(posedge clk_in);
        pins_out <= srt_pin_s'(pins_out | m);
        repeat (4) @(posedge clk_in);
        pins_out <= srt_pin_s'(pins_out & ~m);
        repeat (4) @(posedge clk_in);
    endtask
    task automatic level(input logic [13:0] m, input logic v);
        @(posedge clk_in);
        pins_out <= v ? srt_pin_s'(pins_out | m) : srt_pin_s'(pins_out & ~m);
    endtask
    task automatic trig(input logic [3:0] t);
        @(posedge clk_in);
        trig_out <= t;
        repeat (3) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

//--- testbench/srt_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.svh"
module srt_timer_checker (
    input wire logic        clk_sys_in,
    input wire logic        srst_in,
    input wire logic [7:0]  paddr_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [7:0]  nb_timer_run_out
);
    logic [7:0] wd_lo;
    assign wd_lo = pwdata_in[7:0];
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    a_ready_after_access:
    assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("pready missing after access cycle");
    a_ready_one_pulse:
    assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_ready_has_cause:
    assert property (pready_out |-> $past(psel_in && penable_in))
        else $error("pready without access");
    a_rdata_idle_zero:
    assert property (!pready_out |-> prdata_out == '0)
        else $error("read data not zero outside answer");
    a_err_addr_decode:
    assert property (pready_out |->
        pslverr_out == !(paddr_in <= (`SRT_OFF_OUTPUT_SOURCE_SELECT) && paddr_in[1:0] == 2'h0))
        else $error("slave error does not match address decode");
    a_err_read_zero:
    assert property (pready_out && pslverr_out |-> prdata_out == '0)
        else $error("unmapped read not zero");
    a_run_bits_write:
    assert property (pready_out && pwrite_in && paddr_in == (`SRT_OFF_RUN) |=>
        nb_timer_run_out == $past(wd_lo))
        else $error("run bits not taken from write");
    a_run_bits_hold:
    assert property (!(pready_out && pwrite_in && paddr_in == (`SRT_OFF_RUN)) |=>
        $stable(nb_timer_run_out))
        else $error("run bits changed without write");
    a_setclr_read_zero:
    assert property (pready_out && !pwrite_in && paddr_in == (`SRT_OFF_RUN) |->
        (prdata_out & 32'hffff_ee00) == '0)
        else $error("run set or clear bit reads nonzero");
    a_mode_resv_zero:
    assert property (pready_out && !pwrite_in && paddr_in == (`SRT_OFF_RCCON) |->
        (prdata_out & ~(`SRT_MSK_RCCON)) == '0)
        else $error("mode register reserved bits nonzero");
endmodule
bind srt_timer srt_timer_checker chk_i (
    .clk_sys_in       (clk_sys_in),
    .srst_in          (srst_in),
    .paddr_in         (paddr_in),
    .psel_in          (psel_in),
    .penable_in       (penable_in),
    .pwrite_in        (pwrite_in),
    .pwdata_in        (pwdata_in),
    .prdata_out       (prdata_out),
    .pready_out       (pready_out),
    .pslverr_out      (pslverr_out),
    .nb_timer_run_out (nb_timer_run_out)
);
`default_nettype wire

//--- testbench/split_timer_reload_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.svh"
module split_timer_reload_capture_tb;
    import srt_pkg::*;
    localparam logic [7:0]  o_ctl  = `SRT_OFF_CTRL;
    localparam logic [7:0]  o_run  = `SRT_OFF_RUN;
    localparam logic [7:0]  o_rcc  = `SRT_OFF_RCCON;
    localparam logic [7:0]  o_cnt  = `SRT_OFF_CNT;
    localparam logic [7:0]  o_rc0  = `SRT_OFF_RC0;
    localparam logic [7:0]  o_rc1  = `SRT_OFF_RC1;
    localparam logic [7:0]  o_os   = `SRT_OFF_OUTPUT_SOURCE_SELECT;
    localparam logic [13:0] p_cnt  = 14'h0040;
    localparam logic [13:0] p_ud   = 14'h0020;
    localparam logic [13:0] p_e0   = 14'h0008;
    localparam logic [13:0] p_e1   = 14'h0004;
    localparam logic [13:0] p_hcnt = 14'h2000;
    logic        clk     = 1'b0;
    logic        srst    = 1'b1;
    logic [7:0]  paddr   = '0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    srt_pin_s    pins;
    logic [3:0]  trig;
    logic [7:0]  nbrun;
    logic [7:0]  outev;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // ****************
    // Clock, timeout, instances
    // ****************
    always #5 clk = ~clk;
    // Whole sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            print_verdict();
        end
    end
    srt_timer uut (
        .clk_sys_in       (clk),
        .srst_in          (srst),
        .paddr_in         (paddr),
        .psel_in          (psel),
        .penable_in       (penable),
        .pwrite_in        (pwrite),
        .pwdata_in        (pwdata),
        .prdata_out       (prdata),
        .pready_out       (pready),
        .pslverr_out      (pslverr),
        .pins_in          (pins),
        .nb_trigger_in    (trig),
        .nb_timer_run_out (nbrun),
        .out_event_out    (outev)
    );
    srt_pins_model pm (
        .clk_in   (clk),
        .pins_out (pins),
        .trig_out (trig)
    );
    // ****************
    // Bus and check tasks
    // ****************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, '0, q, e);
        chk($sformatf("reg %h", a), q, x);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        logic [31:0] q;
        logic        e;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++)
            rdc(8'(4 * i), '0);
        apb(1'b0, 8'h1c, '0, q, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        wr(o_rcc, 32'hffff_ffff);
        rdc(o_rcc, 32'h0077_0077);
        wr(o_os, 32'hffff_ffff);
        rdc(o_os, 32'h7777_7777);
        wr(o_os, '0);
        wr(o_run, 32'h0000_00a5);
        chk("nbrun", {24'h0, nbrun}, 32'ha5);
        wr(o_run, 32'h0000_02a5);
        rdc(o_run, 32'h0000_01a5);
        wr(o_run, 32'h0000_06a5);
        rdc(o_run, 32'h0000_01a5);
        wr(o_run, 32'h0000_00a5);
        rdc(o_run, 32'h0000_01a5);
        wr(o_run, 32'h0000_04a5);
        rdc(o_run, 32'h0000_00a5);
        wr(o_run, 32'h0000_01a5);
        rdc(o_run, 32'h0000_00a5);
        wr(o_ctl, 32'h0000_8000);
        wr(o_run, 32'h0000_20a5);
        rdc(o_run, 32'h0000_10a5);
        wr(o_run, 32'h0000_40a5);
        rdc(o_run, 32'h0000_00a5);
        // Count pin source only: clock source would race the reads
        wr(o_run, 32'h0000_0200);
        wr(o_ctl, 32'h0000_0001);
        wr(o_cnt, '0);
        repeat (3) pm.pulse(p_cnt);
        rdc(o_cnt, 32'h3);
        wr(o_ctl, 32'h0000_0005);
        repeat (2) pm.pulse(p_cnt);
        rdc(o_cnt, 32'h1);
        rdc(o_ctl, 32'h0000_1005);
        wr(o_ctl, 32'h0000_0009);
        pm.level(p_ud, 1'b1);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h2);
        wr(o_ctl, 32'h0000_000d);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h1);
        pm.level(p_ud, 1'b0);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h2);
        // Quadrature: direction field says down, pin phase rules
        wr(o_ctl, 32'h0000_0006);
        wr(o_cnt, '0);
        pm.level(p_cnt, 1'b1);
        pm.level(p_ud, 1'b1);
        repeat (4) @(posedge clk);
        rdc(o_cnt, 32'h2);
        pm.level(p_ud, 1'b0);
        pm.level(p_cnt, 1'b0);
        repeat (4) @(posedge clk);
        rdc(o_cnt, '0);
        rdc(o_ctl, 32'h0000_1006);
        wr(o_ctl, 32'h0000_0001);
        wr(o_rcc, 32'h0000_0004);
        wr(o_rc0, 32'h0000_0100);
        wr(o_cnt, 32'hffff_ffff);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h100);
        wr(o_rcc, 32'h0000_0066);
        wr(o_rc1, 32'h0000_0200);
        wr(o_cnt, 32'hffff_ffff);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h100);
        wr(o_ctl, 32'h0000_0005);
        wr(o_cnt, '0);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h200);
        wr(o_rcc, 32'h0000_0033);
        wr(o_ctl, 32'h0000_0011);
        wr(o_cnt, 32'h42);
        pm.pulse(p_e0);
        rdc(o_rc0, 32'h42);
        rdc(o_cnt, '0);
        wr(o_ctl, 32'h0000_0021);
        wr(o_cnt, 32'h43);
        pm.pulse(p_e1);
        rdc(o_rc1, 32'h43);
        rdc(o_cnt, '0);
        wr(o_ctl, 32'h0000_0001);
        wr(o_rcc, 32'h0000_0055);
        wr(o_rc0, 32'h1111);
        wr(o_rc1, 32'h2222);
        pm.pulse(p_e0);
        rdc(o_cnt, 32'h1111);
        pm.pulse(p_e0 | p_e1);
        rdc(o_cnt, 32'h2222);
        wr(o_rcc, 32'h0000_0053);
        wr(o_cnt, 32'h77);
        pm.pulse(p_e0 | p_e1);
        rdc(o_rc0, 32'h77);
        rdc(o_cnt, 32'h2222);
        wr(o_rcc, 32'h0000_0077);
        wr(o_cnt, 32'h5);
        pm.pulse(p_e1);
        rdc(o_cnt, 32'h5);
        pm.pulse(p_e0);
        rdc(o_cnt, 32'h77);
        wr(o_rcc, '0);
        wr(o_ctl, 32'h0001_8001);
        wr(o_run, 32'h0000_2200);
        wr(o_cnt, 32'h0005_0003);
        pm.pulse(p_cnt);
        rdc(o_cnt, 32'h0005_0004);
        pm.pulse(p_hcnt);
        rdc(o_cnt, 32'h0006_0004);
        wr(o_os, 32'h0000_0010);
        pm.trig(4'b0001);
        chk("outev", {24'h0, outev}, 32'hfd);
        pm.trig(4'b0010);
        chk("outev", {24'h0, outev}, 32'h02);
        print_verdict();
    end
endmodule
`default_nettype wire
